// ===== include/scp_pkg.sv
// shared constants and types for the serial configuration port
package scp_pkg;

  // ==========================================================
  // serial framing
  localparam int          BYTE_W    = 8;
  localparam int          CNT_W     = 7;
  localparam int          RW_BIT    = 7;
  localparam logic        RW_READ   = 1'b1;
  localparam int          MEM_DEPTH = 256;
  localparam logic [7:0]  MEM_RESET = 8'h00;
  localparam logic [2:0]  LAST_BIT  = 3'h7;

  // ==========================================================
  // timing of the serial clock made by the host end
  localparam int PCLK_PERIOD_NS = 4;
  localparam int SCLK_PERIOD_NS = 64;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);

  // ==========================================================
  // host register map (apb byte offsets) and fields
  localparam logic [11:0] CFG_OFF         = 12'h000;
  localparam logic [11:0] CMD_OFF         = 12'h004;
  localparam logic [11:0] STAT_OFF        = 12'h008;
  localparam logic [11:0] RX_OFF          = 12'h00c;
  localparam int          CFG_PROTO_BIT   = 0;
  localparam int          CFG_ORDER_BIT   = 1;
  localparam int          CFG_IFSEL_BIT   = 2;
  localparam logic [2:0]  CFG_RESET       = 3'h4;
  localparam int          CMD_READ_BIT    = 8;
  localparam int          CMD_RELEASE_BIT = 9;
  localparam int          STAT_BUSY_BIT   = 0;

  // ==========================================================
  // state machines
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_WRITE, PH_READ} scp_phase_t;
  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_SYNC, HS_FS, HS_BITS, HS_END
  } scp_hstate_t;

endpackage : scp_pkg

// ===== include/scp_link_if.sv
// serial link pins between the host end and the device end
`timescale 1ns/1ns
interface scp_link_if;
  logic sclk;
  logic serial_select_n;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  logic sdo;
  logic transmit_frame_sync;
  logic receive_frame_sync;
  logic bit_order_select;
  logic protocol_select;
  logic interface_select;

  // open drain with pull-up: released line reads high
  assign sdo = sdo_oe ? sdo_out : 1'b1;

  modport device (
    input  sclk, serial_select_n, sdi, transmit_frame_sync,
    input  receive_frame_sync, bit_order_select, protocol_select,
    input  interface_select,
    output sdo_out, sdo_oe
  );

  modport host (
    output sclk, serial_select_n, sdi, transmit_frame_sync,
    output receive_frame_sync, bit_order_select, protocol_select,
    output interface_select,
    input  sdo
  );
endinterface : scp_link_if

// ===== rtl/scp_device.sv
// device end of the serial configuration port with its byte registers
//
// Overview of operation
// - protocol pin: 0 spi, 1 framed
// - interface pin 1 serial, 0 microport
// - select high holds bit logic reset, transfer sequencing kept
// - bit order pin: 1 msb first
// - input sampled on serial clock rise
// - spi clock bursts only, frame syncs ignored
// - spi device is slave only
// - every transfer is one byte
// - first byte is start/end address
// - second byte: read flag, 7-bit count
// - n data bytes, address steps by order
// - output driven on serial clock rise
// - open drain output, released when idle
// - spi read: select low, eight clocks
// - read data in order, sequential addresses
// - every byte location writable and readable
// - framed write: sync clock, eight bits
// - framed read: transmit sync, eight bits
`timescale 1ns/1ns
module scp_device
  import scp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  scp_link_if.device       link,
  input  wire logic [7:0]  core_addr,
  output logic      [7:0]  core_rdata,
  output logic             core_wr_pulse,
  output logic      [7:0]  core_wr_addr,
  output logic      [7:0]  core_wr_data,
  output logic             microport_active
);

  // ==========================================================
  // pin synchronisers
  logic [7:0] pin_raw;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic       sclk_s;
  logic       sel_n_s;
  logic       sdi_s;
  logic       tfs_s;
  logic       rfs_s;
  logic       order_s;
  logic       proto_s;
  logic       ifsel_s;

  assign pin_raw = {link.sclk, link.serial_select_n, link.sdi,
                    link.transmit_frame_sync, link.receive_frame_sync,
                    link.bit_order_select, link.protocol_select,
                    link.interface_select};
  assign {sclk_s, sel_n_s, sdi_s, tfs_s, rfs_s, order_s, proto_s,
          ifsel_s} = sync2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle pin levels: select high and serial port chosen, so no
      // false select or microport flag follows reset
      sync1_reg <= 8'h41;
      sync2_reg <= 8'h41;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // serial clock edges
  logic sclk_prev_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic port_en;
  logic armed;
  logic bit_take;

  // the serial clock is only ever an input here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_s & sclk_prev_reg;
  // serial port works only when selected
  // select high keeps the bit logic idle
  assign port_en   = ifsel_s & ~sel_n_s;

  // ==========================================================
  // byte framing
  logic       armed_rx_reg;
  logic       armed_tx_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic       byte_done_reg;

  assign armed = armed_rx_reg | armed_tx_reg;
  // framed mode needs a sync before the bits
  assign bit_take = sclk_rise & port_en & (~proto_s | armed);

  // shift direction follows the bit order pin
  assign shift_next = order_s ? {shift_reg[6:0], sdi_s}
                              : {sdi_s, shift_reg[7:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_rx_reg  <= 1'b0;
      armed_tx_reg  <= 1'b0;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      byte_done_reg <= 1'b0;
    end else begin
      byte_done_reg <= 1'b0;
      if (!port_en) begin
        // select high resets the bit counter
        armed_rx_reg <= 1'b0;
        armed_tx_reg <= 1'b0;
        bit_cnt_reg  <= 3'h0;
      end else if (bit_take) begin
        // input taken on the rising edge
        shift_reg   <= shift_next;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == LAST_BIT) begin
          byte_done_reg <= 1'b1;
          armed_rx_reg  <= 1'b0;
          armed_tx_reg  <= 1'b0;
        end
      end else if (sclk_rise && proto_s) begin
        // receive sync opens a written byte
        // transmit sync opens a read byte
        if (rfs_s) begin
          armed_rx_reg <= 1'b1;
        end else if (tfs_s) begin
          armed_tx_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // transfer sequencing; survives select high so that each spi
  // read byte may be framed by its own select pulse
  scp_phase_t       phase_reg;
  logic [7:0]       addr_reg;
  logic [CNT_W-1:0] count_reg;
  logic [7:0]       addr_step;

  // increment for lsb first, decrement for msb first
  assign addr_step = order_s ? addr_reg - 8'h01 : addr_reg + 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_ADDR;
      addr_reg  <= 8'h00;
      count_reg <= '0;
    end else if (!ifsel_s) begin
      phase_reg <= PH_ADDR;
    end else if (byte_done_reg) begin
      unique case (phase_reg)
        PH_ADDR: begin
          // first byte is the start or end address
          addr_reg  <= shift_reg;
          phase_reg <= PH_CMD;
        end
        PH_CMD: begin
          count_reg <= shift_reg[CNT_W-1:0];
          if (shift_reg[CNT_W-1:0] == '0) begin
            phase_reg <= PH_ADDR;
          end else if (shift_reg[RW_BIT] == RW_READ) begin
            phase_reg <= PH_READ;
          end else begin
            phase_reg <= PH_WRITE;
          end
        end
        PH_WRITE, PH_READ: begin
          // step address after each data byte
          addr_reg  <= addr_step;
          count_reg <= count_reg - 7'h01;
          // back to instructions after the last byte
          if (count_reg == 7'h01) begin
            phase_reg <= PH_ADDR;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // byte storage
  logic [7:0] mem [MEM_DEPTH];
  logic       wr_hit;

  assign wr_hit = byte_done_reg & ifsel_s & (phase_reg == PH_WRITE);

  // any location written one byte at a time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= MEM_RESET;
      end
    end else if (wr_hit) begin
      mem[addr_reg] <= shift_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_wr_pulse    <= 1'b0;
      core_wr_addr     <= 8'h00;
      core_wr_data     <= 8'h00;
      core_rdata       <= 8'h00;
      microport_active <= 1'b0;
    end else begin
      core_wr_pulse    <= wr_hit;
      if (wr_hit) begin
        core_wr_addr <= addr_reg;
        core_wr_data <= shift_reg;
      end
      core_rdata       <= mem[core_addr];
      // parallel port owns the pins when serial is off
      microport_active <= ~ifsel_s;
    end
  end

  // ==========================================================
  // read data output
  logic [7:0] rd_byte;
  logic [2:0] rd_idx;
  logic       tx_take;
  logic       last_out_reg;

  assign rd_byte = mem[addr_reg];
  // bit order per pin, address order per step
  assign rd_idx  = order_s ? ~bit_cnt_reg : bit_cnt_reg;
  assign tx_take = bit_take & (phase_reg == PH_READ) &
                   (~proto_s | armed_tx_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.sdo_out <= 1'b0;
      link.sdo_oe  <= 1'b0;
      last_out_reg <= 1'b0;
    end else begin
      link.sdo_out <= 1'b0;
      if (!port_en) begin
        // released whenever no read byte is out
        link.sdo_oe  <= 1'b0;
        last_out_reg <= 1'b0;
      end else if (tx_take) begin
        // next bit driven on the rising edge
        // open drain: pull low for a zero only
        link.sdo_oe  <= ~rd_byte[rd_idx];
        last_out_reg <= (bit_cnt_reg == LAST_BIT);
      end else if (sclk_fall && last_out_reg) begin
        // line freed once the eighth bit is taken
        link.sdo_oe  <= 1'b0;
        last_out_reg <= 1'b0;
      end
    end
  end

endmodule : scp_device

// ===== rtl/scp_host.sv
// host end: apb-controlled serial master for the configuration port
`timescale 1ns/1ns
module scp_host
  import scp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  scp_link_if.host         link
);

  // ==========================================================
  // apb slave, one wait state before pready, more while cfg_hold stalls a config write
  logic [2:0]  cfg_reg;
  logic [7:0]  rx_reg;
  logic        busy;
  logic        mapped;
  logic        acc_go;
  logic        cmd_go;
  logic        cfg_wr;
  logic        cfg_hold;
  scp_hstate_t st_reg;

  assign busy   = (st_reg != HS_IDLE);
  assign mapped = (paddr == CFG_OFF) | (paddr == CMD_OFF) |
                  (paddr == STAT_OFF) | (paddr == RX_OFF);
  assign acc_go = psel & penable & pready;
  // a command while busy is dropped, software polls busy first
  assign cmd_go = acc_go & pwrite & (paddr == CMD_OFF) & ~busy;
  assign cfg_wr = acc_go & pwrite & (paddr == CFG_OFF) & ~busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      cfg_reg <= CFG_RESET;
    end else begin
      pready  <= psel & penable & ~pready & ~cfg_hold;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          CFG_OFF:  prdata <= {29'h0, cfg_reg};
          STAT_OFF: prdata <= {31'h0, busy};
          RX_OFF:   prdata <= {24'h0, rx_reg};
          default:  prdata <= 32'h0000_0000;
        endcase
      end
      if (cfg_wr) begin
        cfg_reg <= pwdata[2:0];
      end
    end
  end

  // protocol, interface and bit order pins
  assign link.protocol_select  = cfg_reg[CFG_PROTO_BIT];
  assign link.bit_order_select = cfg_reg[CFG_ORDER_BIT];
  assign link.interface_select = cfg_reg[CFG_IFSEL_BIT];

  // ==========================================================
  // serial clock divider and sdo synchroniser
  logic [3:0] div_reg;
  logic       tick;
  logic       sdo_s1_reg;
  logic       sdo_s2_reg;
  logic       framed;
  logic       order;

  assign tick   = (div_reg == HALF_LAST);
  assign framed = cfg_reg[CFG_PROTO_BIT] & cfg_reg[CFG_IFSEL_BIT];
  assign order  = cfg_reg[CFG_ORDER_BIT];
  // a new mode must never inherit a high serial clock, so a config
  // write waits until the clock sits low and blocks the next toggle
  assign cfg_hold = psel & pwrite & (paddr == CFG_OFF) & ~busy &
                    (link.sclk | (tick & framed));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg    <= 4'h0;
      sdo_s1_reg <= 1'b1;
      sdo_s2_reg <= 1'b1;
      link.sclk  <= 1'b0;
    end else begin
      div_reg    <= tick ? 4'h0 : div_reg + 4'h1;
      sdo_s1_reg <= link.sdo;
      sdo_s2_reg <= sdo_s1_reg;
      // spi clock runs only during a byte
      if (tick && (framed || st_reg == HS_BITS) && !cfg_wr) begin
        link.sclk <= ~link.sclk;
      end
    end
  end

  // ==========================================================
  // byte engine
  logic       fall_t;
  logic       c_read_reg;
  logic       c_rel_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_shift;
  logic [2:0] cnt_reg;

  assign fall_t   = tick & link.sclk;
  assign tx_shift = order ? {tx_reg[6:0], 1'b0} : {1'b0, tx_reg[7:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg                   <= HS_IDLE;
      c_read_reg               <= 1'b0;
      c_rel_reg                <= 1'b0;
      tx_reg                   <= 8'h00;
      rx_reg                   <= 8'h00;
      cnt_reg                  <= 3'h0;
      link.serial_select_n     <= 1'b1;
      link.sdi                 <= 1'b0;
      link.receive_frame_sync  <= 1'b0;
      link.transmit_frame_sync <= 1'b0;
    end else begin
      unique case (st_reg)
        HS_IDLE: begin
          if (cmd_go) begin
            tx_reg     <= pwdata[7:0];
            c_read_reg <= pwdata[CMD_READ_BIT];
            c_rel_reg  <= pwdata[CMD_RELEASE_BIT];
            st_reg     <= HS_START;
          end
        end
        HS_START: begin
          link.serial_select_n <= 1'b0;
          cnt_reg              <= 3'h0;
          if (framed) begin
            st_reg <= HS_SYNC;
          end else begin
            link.sdi <= order ? tx_reg[7] : tx_reg[0];
            st_reg   <= HS_BITS;
          end
        end
        HS_SYNC: begin
          if (fall_t) begin
            // receive sync for a written byte
            // transmit sync for a read byte
            link.receive_frame_sync  <= ~c_read_reg;
            link.transmit_frame_sync <= c_read_reg;
            st_reg                   <= HS_FS;
          end
        end
        HS_FS: begin
          if (fall_t) begin
            link.receive_frame_sync  <= 1'b0;
            link.transmit_frame_sync <= 1'b0;
            link.sdi <= order ? tx_reg[7] : tx_reg[0];
            st_reg   <= HS_BITS;
          end
        end
        HS_BITS: begin
          if (fall_t) begin
            // read bit captured on the falling edge
            rx_reg  <= order ? {rx_reg[6:0], sdo_s2_reg}
                             : {sdo_s2_reg, rx_reg[7:1]};
            cnt_reg <= cnt_reg + 3'h1;
            // next bit changes on the falling edge
            tx_reg   <= tx_shift;
            link.sdi <= order ? tx_shift[7] : tx_shift[0];
            if (cnt_reg == LAST_BIT) begin
              st_reg <= c_rel_reg ? HS_END : HS_IDLE;
            end
          end
        end
        HS_END: begin
          if (tick) begin
            link.serial_select_n <= 1'b1;
            st_reg               <= HS_IDLE;
          end
        end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end

endmodule : scp_host

// ===== test/scp_props.sv
// assertion checker watching the serial link between host and device
`timescale 1ns/1ns
module scp_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sdo,
  input wire logic transmit_frame_sync,
  input wire logic receive_frame_sync,
  input wire logic bit_order_select,
  input wire logic protocol_select,
  input wire logic interface_select
);
  // ==========================================================
  // helper: serial clock rises while selected, modulo one byte
  logic       sclk_q;
  logic [2:0] rise_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rise_cnt <= 3'h0;
    else if (serial_select_n) rise_cnt <= 3'h0;
    else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 3'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // sequences: half and full serial clock periods (16 pclk)
  sequence s_half(logic s);
    s [*8] ##1 !s;
  endsequence
  sequence s_period(logic s);
    s [*8] ##1 s [*8] ##1 !s;
  endsequence

  // ==========================================================
  // properties
  property p_open_drain;
    sdo_oe |-> !sdo_out && !sdo;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("serial output driven high");
  // release lag covers the two sync flops
  property p_release_sel;
    serial_select_n [*5] |-> !sdo_oe;
  endproperty
  a_release_sel: assert property (p_release_sel)
    else $error("output still driven with select high");
  property p_release_ifsel;
    !interface_select [*5] |-> !sdo_oe;
  endproperty
  a_release_ifsel: assert property (p_release_ifsel)
    else $error("output driven while microport selected");
  property p_spi_idle_clk;
    !protocol_select && serial_select_n |-> !sclk;
  endproperty
  a_spi_idle_clk: assert property (p_spi_idle_clk)
    else $error("serial clock high outside a spi frame");
  property p_spi_no_sync;
    !protocol_select |-> !receive_frame_sync && !transmit_frame_sync;
  endproperty
  a_spi_no_sync: assert property (p_spi_no_sync)
    else $error("frame sync raised in spi mode");
  property p_sdi_on_low;
    $changed(sdi) |-> !sclk;
  endproperty
  a_sdi_on_low: assert property (p_sdi_on_low)
    else $error("input data changed while serial clock high");
  property p_sdo_on_high;
    $rose(sdo_oe) |-> sclk;
  endproperty
  a_sdo_on_high: assert property (p_sdo_on_high)
    else $error("output bit launched while serial clock low");
  property p_sclk_half;
    $rose(sclk) |-> s_half(sclk);
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock high phase not 8 cycles");
  property p_rx_sync;
    $rose(receive_frame_sync) |-> s_period(receive_frame_sync);
  endproperty
  a_rx_sync: assert property (p_rx_sync)
    else $error("receive sync not one serial clock long");
  property p_tx_sync;
    $rose(transmit_frame_sync) |-> s_period(transmit_frame_sync);
  endproperty
  a_tx_sync: assert property (p_tx_sync)
    else $error("transmit sync not one serial clock long");
  property p_spi_bytes;
    $rose(serial_select_n) && !protocol_select |-> rise_cnt == 3'h0;
  endproperty
  a_spi_bytes: assert property (p_spi_bytes)
    else $error("spi frame not whole bytes");
endmodule : scp_props

// ===== test/serial_config_port_tb_top.sv
// self-checking bench joining host and device ends over the serial link
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end end
module serial_config_port_tb_top;
  import scp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, core_wr_pulse, microport_active;
  logic [7:0]  core_addr = 8'h00;
  logic [7:0]  core_rdata, core_wr_addr, core_wr_data, wire_sh;
  logic [7:0]  mem [256];
  logic [15:0] wr_q [$];
  int          n_errors = 0;
  int          n_compared = 0;
  integer      seed = 32'hd202cd88;

  always #2 pclk = ~pclk;

  scp_link_if link ();
  scp_host i_scp_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  scp_device i_scp_device (.pclk(pclk), .presetn(presetn), .link(link),
    .core_addr(core_addr), .core_rdata(core_rdata),
    .core_wr_pulse(core_wr_pulse), .core_wr_addr(core_wr_addr),
    .core_wr_data(core_wr_data), .microport_active(microport_active));
  scp_props i_scp_props (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
    .serial_select_n(link.serial_select_n), .sdi(link.sdi),
    .sdo_out(link.sdo_out), .sdo_oe(link.sdo_oe), .sdo(link.sdo),
    .transmit_frame_sync(link.transmit_frame_sync),
    .receive_frame_sync(link.receive_frame_sync),
    .bit_order_select(link.bit_order_select),
    .protocol_select(link.protocol_select),
    .interface_select(link.interface_select));

  // ==========================================================
  // wire monitor: last eight bits seen by the device, first bit on top
  always @(posedge link.sclk) wire_sh <= {wire_sh[6:0], link.sdi};

  // every stored byte must match the next expected location and value
  always @(posedge pclk) begin
    if (core_wr_pulse === 1'b1) begin
      if (wr_q.size() == 0) `CHK(core_wr_pulse, 1'b0)
      else `CHK({core_wr_addr, core_wr_data}, wr_q.pop_front())
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction : rev

  function automatic logic [7:0] loc(input logic [7:0] a, input int i,
                                     input logic ord);
    return ord ? a - 8'(i) : a + 8'(i);
  endfunction : loc

  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // called just after a rising edge; one idle cycle follows
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // one byte with select released after it, so spi reads pulse select
  task automatic send(input logic [7:0] b, input logic rd_bit);
    logic [31:0] w;
    logic        e;
    w = 32'(b);
    w[CMD_READ_BIT] = rd_bit;
    w[CMD_RELEASE_BIT] = 1'b1;
    apb(1'b1, CMD_OFF, w, w, e);
    do apb(1'b0, STAT_OFF, 32'h0, w, e);
    while (w[STAT_BUSY_BIT] !== 1'b0);
  endtask : send

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic        e, ord, pro;
    logic [7:0]  a, d;
    int          n;
    foreach (mem[i]) mem[i] = MEM_RESET;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CFG_OFF, 32'h0, r, e);
    `CHK(r, 32'(CFG_RESET))
    apb(1'b0, 12'h010, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
    // every protocol and bit order, with both address boundaries
    for (int m = 0; m < 4; m++) begin
      pro = m[0];
      ord = m[1];
      n = (m == 0) ? 1 : 2 + int'($unsigned($random(seed)) % 5);
      a = 8'($unsigned($random(seed)) % 200) + (ord ? 8'(n) : 8'h00);
      if (m == 0) a = 8'h00;
      if (m == 3) a = 8'hff;
      apb(1'b1, CFG_OFF, 32'({1'b1, ord, pro}), r, e);
      send(a, 1'b0);
      if (!pro) `CHK(wire_sh, ord ? a : rev(a))
      send({1'b0, 7'(n)}, 1'b0);
      for (int i = 0; i < n; i++) begin
        d = 8'($random(seed));
        mem[loc(a, i, ord)] = d;
        wr_q.push_back({loc(a, i, ord), d});
        send(d, 1'b0);
      end
      send(a, 1'b0);
      send({1'b1, 7'(n)}, 1'b0);
      for (int i = 0; i < n; i++) begin
        send(8'h00, 1'b1);
        apb(1'b0, RX_OFF, 32'h0, r, e);
        `CHK(r[7:0], mem[loc(a, i, ord)])
      end
    end
    // microport selected: serial traffic must change nothing
    apb(1'b1, CFG_OFF, 32'h0, r, e);
    repeat (8) @(posedge pclk);
    `CHK(microport_active, 1'b1)
    send(8'h10, 1'b0);
    send(8'h01, 1'b0);
    send(8'haa, 1'b0);
    apb(1'b1, CFG_OFF, 32'(CFG_RESET), r, e);
    repeat (8) @(posedge pclk);
    `CHK(microport_active, 1'b0)
    for (int i = 0; i < 256; i++) begin
      core_addr <= 8'(i);
      @(posedge pclk);
      @(posedge pclk);
      `CHK(core_rdata, mem[i])
    end
    `CHK(wr_q.size(), 0)
    summarize();
  end
endmodule : serial_config_port_tb_top
